// ===== rtl/sfi_core.sv
// SPI core with mode fault, select output, single-wire, low-power and interrupt
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01: Select output pin is low during each transfer, high while idle.
// RULE_02: Select output works only as master with output and fault enables set.
// RULE_03: Mode fault detection is off while select output is active.
// RULE_04: Single-wire uses MOSI as master, MISO as slave; other pin unused.
// RULE_05: Single-wire direction bit gates driving; shared pin always feeds input.
// RULE_06: SCK output as master, input as slave; select input as slave.
// RULE_07: Master with fault detect sets mode fault on low select input.
// RULE_08: No fault detect or slave mode: select ignored, fault flag clear.
// RULE_09: Fault clears master bit, floats pins, aborts transfer to idle.
// RULE_10: Fault in single-wire master clears the shared pin direction bit.
// RULE_11: Fault flag clears on status read then control one write.
// RULE_12: Received word pending at a mode fault is discarded.
// RULE_13: Port disabled: core idle, registers still writable and readable.
// RULE_14: Wait with wait-stop set freezes a master transfer until exit.
// RULE_15: Slave in wait keeps shifting, sending same word or received word.
// RULE_16: Slave low-power defers completion; flag only if mid-transfer at edge.
// RULE_17: Stop freezes master, slave stays synchronized, ignores wait-stop.
// RULE_18: Data register reads zero after reset.
// RULE_19: Interrupt is OR of three flags, only while port enabled.
// RULE_20: Fault interrupt stays while flag set, drops when cleared.
// RULE_21: Transfer complete sets on data register copy, holds until serviced.
// RULE_22: Transmit empty sets when data register can take data, holds.
// RULE_23: Transfer complete sets half an SCK period after last edge.
// RULE_24: Flags are synchronous to module clock; interrupt is registered.
module sfi_core
	import sfi_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Control register one write
	input wire logic cr1_wr,
	input wire logic cr1_port_enable,
	input wire logic cr1_master_select,
	input wire logic cr1_select_output_enable,
	// Control register two write
	input wire logic cr2_wr,
	input wire logic cr2_fault_detect_enable,
	input wire logic cr2_single_wire_select,
	input wire logic cr2_single_wire_output_enable,
	input wire logic cr2_wait_stop_bit,
	// Data and status access
	input wire logic data_wr,
	input wire logic [7:0] data_wdata,
	input wire logic data_rd,
	input wire logic status_rd,
	// System power state
	input wire logic cpu_wait,
	input wire logic cpu_stop,
	// Register readback
	output logic [7:0] port_data_register,
	output logic mode_fault_flag,
	output logic transfer_complete_flag,
	output logic transmit_empty_flag,
	output logic master_select,
	output logic single_wire_output_enable,
	output logic irq,
	// Serial pins
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic ss_in,
	output logic ss_out,
	output logic ss_oe
);

	////////////////////////////////////////////////////////////////
	logic port_enable, select_output_enable, fault_detect_enable;
	logic single_wire_select, wait_stop_bit;
	logic [2:0] s1, s2;
	logic sck_s3;
	sfi_state_t state;
	logic [4:0] cnt;
	logic [3:0] hcnt, tcnt;
	logic sck, rx_bit, lp_q, lp_mid, held, pend;
	logic [7:0] shreg, tx_reg, pend_word, hold_word;
	logic mode_fault_flag_armed, tcf_armed, tef_armed;
	logic [7:0] mem [0:1];
	logic wptr, rptr;
	logic [1:0] fcnt;

	// Two-flop synchronisers for pins from the far side
	always_ff @(posedge mclk) begin
		s1 <= {sck_in, ss_in, mosi_in};
		s2 <= s1;
		sck_s3 <= s2[2];
	end
	logic miso_s1, miso_s2;
	always_ff @(posedge mclk) begin
		miso_s1 <= miso_in;
		miso_s2 <= miso_s1;
	end

	////////////////////////////////////////////////////////////////
	// Mode decode
	wire sck_s2 = s2[2];
	wire ss_s2 = s2[1];
	wire mosi_s2 = s2[0];
	wire lp = cpu_stop | (cpu_wait & wait_stop_bit);
	wire freeze = master_select & lp;
	wire s_lp = !master_select & lp;
	wire slave_on = port_enable & !master_select & !mode_fault_flag;
	// RULE_02 select output gating
	wire ssout_act = master_select & select_output_enable & fault_detect_enable;
	// RULE_03 off with select output, RULE_07 low select faults, RULE_08 master only
	wire fault_set = port_enable & master_select & fault_detect_enable & !select_output_enable & !ss_s2;
	// RULE_05 shared pin always feeds the shift register
	wire sw_in = master_select ? mosi_s2 : miso_s2;
	wire nw_in = master_select ? miso_s2 : mosi_s2;
	wire sdi = single_wire_select ? sw_in : nw_in;

	// Sequencer decode
	wire busy = (state == SFI_SHIFT);
	wire h_done = (hcnt == HALF_LAST);
	wire m_tick = master_select & busy & !freeze & h_done;
	wire s_rise = slave_on & busy & sck_s2 & !sck_s3;
	wire s_fall = slave_on & busy & !sck_s2 & sck_s3;
	wire do_sample = (m_tick & !sck) | s_rise;
	wire do_shift = (m_tick & sck) | s_fall;
	wire word_done = do_shift & (cnt == LAST_EDGE - EDGE_ONE);
	wire [7:0] next_shreg = {shreg[MSB-1:0], rx_bit};
	wire fifo_in_ready = (fcnt != FIFO_FULL);
	wire start_m = port_enable & master_select & !freeze & !transmit_empty_flag
		& fifo_in_ready & !pend & !busy & !fault_set;
	wire start_s = slave_on & !busy & !ss_s2;
	wire s_abort = busy & !master_select & ss_s2;
	wire lp_rise = lp & !lp_q;
	wire lp_fall = !lp & lp_q;
	wire mid = busy & (cnt != 5'h00);
	wire t_done = pend & (tcnt == HALF_LAST) & !freeze;
	wire push = t_done & fifo_in_ready;
	wire fifo_out_valid = (fcnt != FIFO_EMPTY);
	wire pop = fifo_out_valid & !transfer_complete_flag;

	////////////////////////////////////////////////////////////////
	// Control registers; the fault overrides a same-cycle write
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			port_enable <= 1'b0;
			master_select <= 1'b0;
			select_output_enable <= 1'b0;
			fault_detect_enable <= 1'b0;
			single_wire_select <= 1'b0;
			single_wire_output_enable <= 1'b0;
			wait_stop_bit <= 1'b0;
		end else begin
			if (cr1_wr) begin
				port_enable <= cr1_port_enable;
				select_output_enable <= cr1_select_output_enable;
			end
			// RULE_09 fault drops master bit
			if (fault_set)
				master_select <= 1'b0;
			else if (cr1_wr)
				master_select <= cr1_master_select;
			if (cr2_wr) begin
				fault_detect_enable <= cr2_fault_detect_enable;
				single_wire_select <= cr2_single_wire_select;
				wait_stop_bit <= cr2_wait_stop_bit;
			end
			// RULE_10 shared pin direction cleared on fault
			if (fault_set & single_wire_select)
				single_wire_output_enable <= 1'b0;
			else if (cr2_wr)
				single_wire_output_enable <= cr2_single_wire_output_enable;
		end
	end

	////////////////////////////////////////////////////////////////
	// Sequencer: master clock generation and slave edge following
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state <= SFI_IDLE;
			cnt <= 5'h00;
			hcnt <= 4'h0;
			sck <= 1'b0;
			rx_bit <= 1'b0;
			shreg <= DATA_RST;
		// RULE_09 abort on fault, RULE_13 idle while disabled
		end else if (fault_set | !port_enable | s_abort) begin
			state <= SFI_IDLE;
			cnt <= 5'h00;
			hcnt <= 4'h0;
			sck <= 1'b0;
		end else if (start_m | start_s) begin
			state <= SFI_SHIFT;
			cnt <= 5'h00;
			hcnt <= 4'h0;
			shreg <= tx_reg;
		end else begin
			// RULE_14 master holds count while frozen, RULE_17 stop too
			if (master_select & busy & !freeze)
				hcnt <= h_done ? 4'h0 : hcnt + 4'h1;
			if (m_tick)
				sck <= !sck;
			if (do_sample)
				rx_bit <= sdi;
			if (do_shift)
				shreg <= next_shreg;
			if (do_sample | do_shift)
				cnt <= word_done ? 5'h00 : cnt + EDGE_ONE;
			// Slave stays in shift so an unbroken select resends the received word
			if (word_done & master_select)
				state <= SFI_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////
	// Completion tail and slave low-power deferral
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			lp_q <= 1'b0;
			lp_mid <= 1'b0;
			held <= 1'b0;
			hold_word <= DATA_RST;
		end else begin
			lp_q <= lp;
			// RULE_16 remember a transfer running at entry
			if (lp_rise & !master_select)
				lp_mid <= mid;
			else if (lp_fall)
				lp_mid <= 1'b0;
			// RULE_15 slave keeps shifting, last word held until exit
			if (word_done & s_lp) begin
				held <= 1'b1;
				hold_word <= next_shreg;
			end else if (lp_fall)
				held <= 1'b0;
		end
	end

	// Pending word waits half an SCK period before it is copied
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pend <= 1'b0;
			tcnt <= 4'h0;
			pend_word <= DATA_RST;
		// RULE_12 discard on fault, RULE_16 lost at slave low-power entry
		end else if (fault_set | !port_enable | (lp_rise & !master_select)) begin
			pend <= 1'b0;
		// RULE_23 half period tail after last edge
		end else if (word_done & !s_lp) begin
			pend <= 1'b1;
			tcnt <= 4'h0;
			pend_word <= next_shreg;
		// RULE_16 copy at exit only when mid-transfer at entry or exit
		end else if (lp_fall & held & !master_select & (lp_mid | mid)) begin
			pend <= 1'b1;
			tcnt <= 4'h0;
			pend_word <= hold_word;
		end else if (t_done) begin
			pend <= 1'b0;
		end else if (pend & !freeze) begin
			tcnt <= tcnt + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Two-entry receive buffer; a full buffer holds off the master
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			wptr <= 1'b0;
			rptr <= 1'b0;
			fcnt <= FIFO_EMPTY;
		end else begin
			if (push) begin
				mem[wptr] <= pend_word;
				wptr <= !wptr;
			end
			if (pop)
				rptr <= !rptr;
			fcnt <= fcnt + {1'b0, push} - {1'b0, pop};
		end
	end

	////////////////////////////////////////////////////////////////
	// Data registers and flags; a set wins over a same-cycle clear
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			// RULE_18 data register reads zero after reset
			port_data_register <= DATA_RST;
			tx_reg <= DATA_RST;
			mode_fault_flag <= 1'b0;
			transfer_complete_flag <= 1'b0;
			transmit_empty_flag <= 1'b1;
			mode_fault_flag_armed <= 1'b0;
			tcf_armed <= 1'b0;
			tef_armed <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (data_wr)
				tx_reg <= data_wdata;
			// RULE_07 fault set, RULE_11 read-then-write clear
			if (fault_set)
				mode_fault_flag <= 1'b1;
			else if (mode_fault_flag_armed & cr1_wr)
				mode_fault_flag <= 1'b0;
			mode_fault_flag_armed <= (status_rd & mode_fault_flag) | (mode_fault_flag_armed & !cr1_wr);
			// RULE_21 complete flag set on data register copy
			if (pop) begin
				port_data_register <= mem[rptr];
				transfer_complete_flag <= 1'b1;
			end else if (tcf_armed & data_rd)
				transfer_complete_flag <= 1'b0;
			tcf_armed <= (status_rd & transfer_complete_flag) | (tcf_armed & !data_rd);
			// RULE_22 empty flag set once the word is taken for shifting
			if (start_m | start_s)
				transmit_empty_flag <= 1'b1;
			else if (tef_armed & data_wr)
				transmit_empty_flag <= 1'b0;
			tef_armed <= (status_rd & transmit_empty_flag) | (tef_armed & !data_wr);
			// RULE_19 RULE_20 RULE_24 registered OR of flags
			irq <= port_enable & (mode_fault_flag | transfer_complete_flag | transmit_empty_flag);
		end
	end

	////////////////////////////////////////////////////////////////
	// RULE_06 SCK direction by mode
	assign sck_oe = port_enable & master_select;
	assign sck_out = sck;
	// RULE_04 RULE_05 data pin selection and direction
	assign mosi_oe = port_enable & master_select & (!single_wire_select | single_wire_output_enable);
	// RULE_09 slave buffer off while the fault stands
	assign miso_oe = slave_on & !ss_s2 & (!single_wire_select | single_wire_output_enable);
	assign mosi_out = shreg[MSB];
	assign miso_out = shreg[MSB];
	// RULE_01 select output low while busy
	assign ss_oe = port_enable & ssout_act;
	assign ss_out = !busy;

	////////////////////////////////////////////////////////////////
	ssout_low_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_01
		ss_oe && busy |-> !ss_out) else $error("select output high during transfer");
	ssout_gate_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_02
		ss_oe |-> master_select && select_output_enable && fault_detect_enable)
		else $error("select output driven outside master");
	fault_set_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_07
		port_enable && master_select && fault_detect_enable && !select_output_enable && !ss_s2
		|=> mode_fault_flag && !master_select) else $error("mode fault not raised");
	fault_quiet_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_08
		!master_select && !mode_fault_flag |=> !mode_fault_flag)
		else $error("mode fault raised in slave");
	fault_abort_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_09
		$rose(mode_fault_flag) |-> state == SFI_IDLE && !sck_oe && !mosi_oe && !miso_oe)
		else $error("fault did not abort and float");
	bidir_pin_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_04
		single_wire_select && master_select |-> !miso_oe) else $error("unused pin driven");
	sck_dir_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_06
		!master_select |-> !sck_oe) else $error("slave drives SCK");
	freeze_hold_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_14
		freeze && busy && !fault_set && port_enable |=> $stable(cnt) && $stable(sck))
		else $error("frozen master moved");
	irq_off_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_19
		!port_enable |=> !irq) else $error("interrupt while disabled");
	tail_time_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_23
		t_done |-> $past(pend, 7)) else $error("completion before half period");
	mode_fault_flag_clear_a: assert property (@(posedge mclk) disable iff (!nrst) // RULE_11
		$fell(mode_fault_flag) |-> $past(cr1_wr) && $past(mode_fault_flag_armed))
		else $error("fault flag cleared without sequence");

endmodule : sfi_core
`default_nettype wire

// ===== rtl/sfi_pkg.sv
// Constants and types shared by the fault, low-power and interrupt SPI core
package sfi_pkg;
	// Module clock and serial clock timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCK_HALF_NS = 64;
	localparam int HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
	// Transfer shape: eight bits give sixteen clock edges
	localparam logic [4:0] LAST_EDGE = 5'h10;
	localparam logic [4:0] EDGE_ONE = 5'h01;
	localparam int MSB = 7;
	// Reset values and receive buffer full level
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [1:0] FIFO_FULL = 2'h2;
	localparam logic [1:0] FIFO_EMPTY = 2'h0;
	// Core sequencer states
	typedef enum logic [1:0] {
		SFI_IDLE = 2'b00,
		SFI_SHIFT = 2'b01
	} sfi_state_t;
endpackage : sfi_pkg

// ===== tb/sfi_far_end.sv
// Far-end SPI device model: mode 0 slave and master
`timescale 1ns/1ps
`default_nettype none
module sfi_far_end (
	// Resolved pins
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic ss,
	// Answer word and word seen
	input wire logic [7:0] reply,
	output logic [7:0] got,
	// Drives of this end
	output logic s_miso,
	output logic m_ss,
	output logic m_sck,
	output logic m_mosi
);
	logic [7:0] sh;
	logic m_act;
	// Idle: deselected, clock low
	initial begin
		{got, sh} = 16'h0000;
		{s_miso, m_ss, m_sck, m_mosi, m_act} = 5'h08;
	end
	always @(negedge ss) begin
		sh = reply;
		s_miso = reply[7];
	end
	// Released line flips so a stale bit never passes
	always @(posedge ss) s_miso = ~s_miso;
	// Sample on rise
	always @(posedge sck) if (!ss) got = {got[6:0], m_act ? miso : mosi};
	// Shift on fall
	always @(negedge sck) if (!ss && !m_act) begin
		sh = {sh[6:0], 1'b0};
		s_miso = sh[7];
	end
	// far master drives SCK, 125 ns period
	task automatic drive(input logic [7:0] w);
		m_act = 1'b1;
		m_ss = 1'b0;
		#62.5;
		for (int i = 7; i >= 0; i--) begin
			m_mosi = w[i];
			#62.5 m_sck = 1'b1;
			#62.5 m_sck = 1'b0;
		end
		#62.5 m_ss = 1'b1;
		m_mosi = ~m_mosi;
		m_act = 1'b0;
	endtask : drive
endmodule : sfi_far_end
`default_nettype wire

// ===== tb/sfi_core_tb.sv
// Self-checking bench for the SPI fault and interrupt core
`timescale 1ns/1ps
`default_nettype none
module sfi_core_tb;
	logic mclk, nrst, cr1_wr, cr2_wr, data_wr, data_rd, status_rd, cpu_wait, cpu_stop, f_ss;
	logic cr1_port_enable, cr1_master_select, cr1_select_output_enable;
	logic cr2_fault_detect_enable, cr2_single_wire_select, cr2_single_wire_output_enable, cr2_wait_stop_bit;
	logic [7:0] data_wdata, reply, got, port_data_register;
	logic mode_fault_flag, transfer_complete_flag, transmit_empty_flag, master_select;
	logic single_wire_output_enable, irq, s_miso, m_ss, m_sck, m_mosi;
	logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_out, ss_oe;
	int n_mismatch = 0;
	int checks = 0;
	// Pin levels from all drivers
	wire logic sck_p = sck_oe ? sck_out : m_sck;
	wire logic mosi_p = mosi_oe ? mosi_out : m_mosi;
	wire logic miso_p = miso_oe ? miso_out : s_miso;
	wire logic ss_p = ss_oe ? ss_out : (m_ss & f_ss);
	always #4 mclk = ~mclk;
	sfi_core i_sfi_core (.mclk, .nrst, .cr1_wr, .cr1_port_enable, .cr1_master_select,
		.cr1_select_output_enable, .cr2_wr, .cr2_fault_detect_enable, .cr2_single_wire_select,
		.cr2_single_wire_output_enable, .cr2_wait_stop_bit, .data_wr, .data_wdata, .data_rd,
		.status_rd, .cpu_wait, .cpu_stop, .port_data_register, .mode_fault_flag,
		.transfer_complete_flag, .transmit_empty_flag, .master_select, .single_wire_output_enable,
		.irq, .sck_in(sck_p), .sck_out, .sck_oe, .mosi_in(mosi_p), .mosi_out, .mosi_oe,
		.miso_in(miso_p), .miso_out, .miso_oe, .ss_in(ss_p), .ss_out, .ss_oe);
	sfi_far_end i_sfi_far_end (.sck(sck_p), .mosi(mosi_p), .miso(miso_p), .ss(ss_p), .reply,
		.got, .s_miso, .m_ss, .m_sck, .m_mosi);
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	// Byte compare
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// Bit compare
	task automatic chkb(input logic g, input logic e);
		chk({7'h00, g}, {7'h00, e});
	endtask : chkb
	// One-cycle strobes {cr1_wr, cr2_wr, data_wr, data_rd, status_rd}
	task automatic strobe(input logic [4:0] s);
		@(negedge mclk);
		{cr1_wr, cr2_wr, data_wr, data_rd, status_rd} = s;
		@(negedge mclk);
		{cr1_wr, cr2_wr, data_wr, data_rd, status_rd} = 5'h00;
	endtask : strobe
	// Both control writes at once
	task automatic cfg(input logic [2:0] c1, input logic [3:0] c2);
		{cr1_port_enable, cr1_master_select, cr1_select_output_enable} = c1;
		{cr2_fault_detect_enable, cr2_single_wire_select, cr2_single_wire_output_enable,
			cr2_wait_stop_bit} = c2;
		strobe(5'h18);
	endtask : cfg
	// Bounded wait: 0 complete, 1 fault, 2 select low, 3 select high
	task automatic await(input int k);
		int i;
		for (i = 0; i < 500; i++) begin
			@(negedge mclk);
			if ((k == 0 && transfer_complete_flag === 1'b1) || (k == 1 && mode_fault_flag === 1'b1)
				|| (k == 2 && ss_out === 1'b0) || (k == 3 && ss_out === 1'b1))
				break;
		end
		if (i == 500) begin
			n_mismatch++;
			$display("[ERR] %0t wait %0d timed out", $time, k);
			wrap_up;
		end
	endtask : await
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		strobe(5'h02);
		chk(port_data_register, 8'h00);
		chkb(transmit_empty_flag, 1'b1);
		chkb(irq, 1'b0);
	endtask : t_reset
	// Master with select output; far slave answers
	task automatic t_master;
		reply = 8'h96;
		cfg(3'h7, 4'h8);
		chkb(ss_oe, 1'b1);
		chkb(ss_out, 1'b1);
		data_wdata = 8'h5B;
		strobe(5'h01);
		strobe(5'h04);
		await(2);
		repeat (60) @(negedge mclk);
		chkb(ss_p, 1'b0);
		chkb(sck_oe, 1'b1);
		chkb(mode_fault_flag, 1'b0);
		await(3);
		repeat (8) @(negedge mclk);
		chkb(transfer_complete_flag, 1'b0);
		repeat (1) @(negedge mclk);
		chkb(transfer_complete_flag, 1'b1);
		chk(port_data_register, 8'h96);
		chk(got, 8'h5B);
		chkb(irq, 1'b1);
		chkb(transmit_empty_flag, 1'b1);
		repeat (20) @(negedge mclk);
		chkb(transfer_complete_flag, 1'b1);
		strobe(5'h01);
		strobe(5'h02);
		chkb(transfer_complete_flag, 1'b0);
	endtask : t_master
	// Slave; far master clocks a word
	task automatic t_slave;
		cfg(3'h4, 4'h0);
		data_wdata = 8'hA5;
		strobe(5'h01);
		strobe(5'h04);
		chkb(sck_oe, 1'b0);
		i_sfi_far_end.drive(8'h3C);
		await(0);
		chk(port_data_register, 8'h3C);
		chk(got, 8'hA5);
		chkb(mode_fault_flag, 1'b0);
	endtask : t_slave
	// Select pulled low by a rival master
	task automatic t_fault;
		cfg(3'h6, 4'h0);
		f_ss = 1'b0;
		repeat (10) @(negedge mclk);
		chkb(mode_fault_flag, 1'b0);
		chkb(master_select, 1'b1);
		cfg(3'h6, 4'hE);
		await(1);
		chkb(master_select, 1'b0);
		chkb(sck_oe | mosi_oe | miso_oe, 1'b0);
		chkb(single_wire_output_enable, 1'b0);
		f_ss = 1'b1;
		repeat (4) @(negedge mclk);
		chkb(irq & mode_fault_flag, 1'b1);
		strobe(5'h01);
		cfg(3'h6, 4'h8);
		chkb(mode_fault_flag, 1'b0);
		chkb(master_select, 1'b1);
		cfg(3'h0, 4'h0);
		repeat (2) @(negedge mclk);
		chkb(irq, 1'b0);
	endtask : t_fault
	// Single-wire master reads its own word back; wait, then stop, freeze it mid-word
	task automatic t_wire_wait;
		logic s;
		cfg(3'h6, 4'h7);
		strobe(5'h01);
		strobe(5'h02);
		data_wdata = 8'hC3;
		strobe(5'h04);
		for (int k = 0; k < 2; k++) begin
			repeat (24) @(negedge mclk);
			chkb(mosi_oe, 1'b1);
			chkb(miso_oe, 1'b0);
			{cpu_stop, cpu_wait} = k ? 2'h2 : 2'h1;
			s = sck_out;
			repeat (24) begin
				@(negedge mclk);
				chkb(sck_out, s);
			end
			chkb(transfer_complete_flag, 1'b0);
			{cpu_stop, cpu_wait} = 2'h0;
		end
		await(0);
		chk(port_data_register, 8'hC3);
	endtask : t_wire_wait
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{mclk, nrst, cr1_wr, cr2_wr, data_wr, data_rd, status_rd, cpu_wait, cpu_stop} = 9'h000;
		{cr1_port_enable, cr1_master_select, cr1_select_output_enable} = 3'h0;
		{cr2_fault_detect_enable, cr2_single_wire_select, cr2_single_wire_output_enable,
			cr2_wait_stop_bit} = 4'h0;
		{data_wdata, reply} = 16'h0000;
		f_ss = 1'b1;
		repeat (4) @(negedge mclk);
		nrst = 1'b1;
		t_reset;
		t_master;
		t_slave;
		t_fault;
		t_wire_wait;
		wrap_up;
	end
endmodule : sfi_core_tb
`default_nettype wire
